// File: rtl/pcs_capture.sv
/*
 * Two-channel position capture unit with its status and captured-position
 * objects, read by object index.
 * Assumes: control word and homing flag come from logic on clk_sys_in;
 * probe and encoder zero inputs are asynchronous pins.
 */

// Functional notes
// - status bits 0/8 show channel enabled
// - bits 1/9 show rising capture held
// - bits 2/10 show falling capture held
// - continuous mode toggles bit 7/15 per capture
// - status bits 3-6, 11-14 read zero
// - status is read-only 16-bit object
// - rising edge stores signed 32-bit position
// - falling edge stores signed 32-bit position
// - enable bit; single or continuous capture mode
// - select bit picks probe or encoder zero
// - separate rising and falling sampling enables
// - homing start disables channel 1
`timescale 1ns/100ps
`include "pcs_defines.svh"

module pcs_capture (
  input wire logic clk_sys_in, // 40 MHz system clock
  input wire logic rstn_in, // Asynchronous reset, active low
  input wire pcs_pkg::pcs_word_t ctrl_word_in, // Capture control word
  input wire logic homing_in, // High while homing runs
  input wire logic [1:0] probe_in, // External probe pins
  input wire logic enc_zero_in, // Encoder zero pulse pin
  input wire pcs_pkg::pcs_pos_t pos_in, // Current user position
  input wire logic obj_rd_in, // Object read strobe
  input wire pcs_pkg::pcs_index_t obj_index_in, // Object index
  output logic [31:0] obj_data_out, // Read data
  output logic obj_ack_out, // Read answered, one cycle
  output logic obj_err_out // Unmapped index, one cycle
);

  logic [1:0] probe_m_q;
  logic [1:0] probe_s_q;
  logic zero_m_q;
  logic zero_s_q;
  logic home_prev_q;
  logic home_block_q;
  logic [`PCS_NUM_CH-1:0] ch_en;
  logic [`PCS_NUM_CH-1:0] rise_held;
  logic [`PCS_NUM_CH-1:0] fall_held;
  logic [`PCS_NUM_CH-1:0] tog;
  pcs_pkg::pcs_word_t status_w;

  // Pin synchronisers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      probe_m_q <= 2'h0;
      probe_s_q <= 2'h0;
      zero_m_q <= 1'h0;
      zero_s_q <= 1'h0;
    end else begin
      probe_m_q <= probe_in;
      probe_s_q <= probe_m_q;
      zero_m_q <= enc_zero_in;
      zero_s_q <= zero_m_q;
    end
  end

  // Homing start blocks channel 1 until software drops its enable
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      home_prev_q <= 1'h0;
      home_block_q <= 1'h0;
    end else begin
      home_prev_q <= homing_in;
      if (homing_in && !home_prev_q &&
          ctrl_word_in[`PCS_CTL_EN]) begin
        home_block_q <= 1'h1;
      end else if (!ctrl_word_in[`PCS_CTL_EN]) begin
        home_block_q <= 1'h0;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PCS_NUM_CH; i = i + 1) begin : ch
      localparam int B = i * `PCS_CH_STRIDE;
      logic en;
      logic trig;
      logic trig_q;
      logic rise_ev;
      logic fall_ev;
      logic rise_arm_q;
      logic fall_arm_q;
      logic rise_flag_q;
      logic fall_flag_q;
      logic tog_q;
      logic cap_rise;
      logic cap_fall;
      logic rise_restart;
      logic fall_restart;
      pcs_pkg::pcs_pos_t rise_pos_q;
      pcs_pkg::pcs_pos_t fall_pos_q;

      if (i == `PCS_HOMING_CH) begin : g_home
        assign en = ctrl_word_in[B+`PCS_CTL_EN] &
                    ~homing_in & ~home_block_q;
      end else begin : g_plain
        assign en = ctrl_word_in[B+`PCS_CTL_EN];
      end

      assign trig = ctrl_word_in[B+`PCS_CTL_SEL] ?
                    zero_s_q : probe_s_q[i];
      assign rise_ev = en && trig && !trig_q;
      assign fall_ev = en && !trig && trig_q;
      // Single mode takes only the first event per edge
      assign cap_rise = rise_ev && ctrl_word_in[B+`PCS_CTL_RISE] &&
        (ctrl_word_in[B+`PCS_CTL_CONT] || !rise_flag_q);
      assign cap_fall = fall_ev && ctrl_word_in[B+`PCS_CTL_FALL] &&
        (ctrl_word_in[B+`PCS_CTL_CONT] || !fall_flag_q);
      assign rise_restart = !en ||
        (ctrl_word_in[B+`PCS_CTL_RISE] && !rise_arm_q);
      assign fall_restart = !en ||
        (ctrl_word_in[B+`PCS_CTL_FALL] && !fall_arm_q);

      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          trig_q <= 1'h0;
          rise_arm_q <= 1'h0;
          fall_arm_q <= 1'h0;
        end else begin
          trig_q <= trig;
          rise_arm_q <= en && ctrl_word_in[B+`PCS_CTL_RISE];
          fall_arm_q <= en && ctrl_word_in[B+`PCS_CTL_FALL];
        end
      end

      // Set wins over restart in the same cycle
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          rise_flag_q <= 1'h0;
          fall_flag_q <= 1'h0;
        end else begin
          if (cap_rise) begin
            rise_flag_q <= 1'h1;
          end else if (rise_restart) begin
            rise_flag_q <= 1'h0;
          end
          if (cap_fall) begin
            fall_flag_q <= 1'h1;
          end else if (fall_restart) begin
            fall_flag_q <= 1'h0;
          end
        end
      end

      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          tog_q <= 1'h0;
        end else if (ctrl_word_in[B+`PCS_CTL_CONT] &&
                     (cap_rise || cap_fall)) begin
          tog_q <= ~tog_q;
        end
      end

      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          rise_pos_q <= `PCS_POS_RST;
          fall_pos_q <= `PCS_POS_RST;
        end else begin
          if (cap_rise) begin
            rise_pos_q <= pos_in;
          end
          if (cap_fall) begin
            fall_pos_q <= pos_in;
          end
        end
      end

      assign ch_en[i] = en;
      assign rise_held[i] = rise_flag_q;
      assign fall_held[i] = fall_flag_q;
      assign tog[i] = tog_q;
    end
  endgenerate

  always_comb begin
    status_w = `PCS_WORD_RST;
    for (int c = 0; c < `PCS_NUM_CH; c++) begin
      status_w[c*`PCS_CH_STRIDE+`PCS_ST_EN] = ch_en[c];
      status_w[c*`PCS_CH_STRIDE+`PCS_ST_RISE] = rise_held[c];
      status_w[c*`PCS_CH_STRIDE+`PCS_ST_FALL] = fall_held[c];
      status_w[c*`PCS_CH_STRIDE+`PCS_ST_TOG] = tog[c];
    end
  end

  // Read-only object access; no write path exists
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      obj_data_out <= `PCS_DATA_RST;
      obj_ack_out <= 1'h0;
      obj_err_out <= 1'h0;
    end else begin
      obj_ack_out <= obj_rd_in;
      obj_err_out <= 1'h0;
      if (obj_rd_in) begin
        unique case (obj_index_in)
          `PCS_IDX_STATUS: obj_data_out <= {`PCS_WORD_RST, status_w};
          `PCS_IDX_CH1_RISE: obj_data_out <= ch[0].rise_pos_q;
          `PCS_IDX_CH1_FALL: obj_data_out <= ch[0].fall_pos_q;
          `PCS_IDX_CH2_RISE: obj_data_out <= ch[1].rise_pos_q;
          `PCS_IDX_CH2_FALL: obj_data_out <= ch[1].fall_pos_q;
          default: begin
            obj_data_out <= `PCS_DATA_RST;
            obj_err_out <= 1'h1;
          end
        endcase
      end
    end
  end

endmodule : pcs_capture

// File: rtl/pcs_defines.svh
/*
 * Constants of the position capture unit: object indices, bit positions
 * of the control and status words, and reset values.
 * Assumes inclusion by bare name from the capture module.
 */
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

`define PCS_IDX_STATUS 16'h60B9
`define PCS_IDX_CH1_RISE 16'h60BA
`define PCS_IDX_CH1_FALL 16'h60BB
`define PCS_IDX_CH2_RISE 16'h60BC
`define PCS_IDX_CH2_FALL 16'h60BD

`define PCS_NUM_CH 2
`define PCS_CH_STRIDE 8
`define PCS_HOMING_CH 0

`define PCS_CTL_EN 0
`define PCS_CTL_CONT 1
`define PCS_CTL_SEL 2
`define PCS_CTL_RISE 4
`define PCS_CTL_FALL 5

`define PCS_ST_EN 0
`define PCS_ST_RISE 1
`define PCS_ST_FALL 2
`define PCS_ST_TOG 7

`define PCS_POS_RST 32'h0000_0000
`define PCS_WORD_RST 16'h0000
`define PCS_DATA_RST 32'h0000_0000

`endif

// File: rtl/pcs_pkg.sv
/*
 * Types shared by the position capture unit.
 * Assumes nothing beyond the constants header.
 */
package pcs_pkg;
  typedef logic signed [31:0] pcs_pos_t;
  typedef logic [15:0] pcs_word_t;
  typedef logic [15:0] pcs_index_t;
endpackage : pcs_pkg

// File: tb/pcs_master.sv
/* Fieldbus master model issuing object reads.
   Assumes one-cycle strobes. */
`timescale 1ns/100ps
module pcs_master (
  input wire logic clk_sys_in, // Clock
  output pcs_pkg::pcs_index_t idx_out, // Index
  output logic rd_out // Strobe
);
  initial begin
    rd_out = 1'b0;
    idx_out = 16'h0000;
  end
  task automatic rd(input pcs_pkg::pcs_index_t i);
    @(negedge clk_sys_in);
    rd_out = 1'b1;
    idx_out = i;
    @(negedge clk_sys_in);
    rd_out = 1'b0;
    idx_out = ~i;
  endtask : rd
endmodule : pcs_master

// File: tb/pcs_props.sv
/* Port checker for the capture unit.
   Assumes a bind onto each pcs_capture. */
`timescale 1ns/100ps
module pcs_props (
  input wire logic clk_sys_in, // Clock
  input wire logic rstn_in, // Reset, low
  input wire pcs_pkg::pcs_word_t ctrl_word_in, // Control
  input wire logic homing_in, // Homing
  input wire logic obj_rd_in, // Read
  input wire pcs_pkg::pcs_index_t obj_index_in, // Index
  input wire logic [31:0] obj_data_out, // Data
  input wire logic obj_ack_out, // Ack
  input wire logic obj_err_out // Error
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_st;
    obj_rd_in && obj_index_in == 16'h60B9;
  endsequence
  sequence s_bad;
    obj_rd_in && (obj_index_in < 16'h60B9 || obj_index_in > 16'h60BD);
  endsequence
  property p_ack; obj_rd_in |=> obj_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_err; s_bad |=> obj_err_out && obj_data_out == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad index");
  property p_hold; !obj_rd_in |=> $stable(obj_data_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_rsv;
    s_st |=> obj_data_out[31:16] == 16'h0 && obj_data_out[6:3] == 4'h0
      && obj_data_out[14:11] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_en1; s_st ##0 !ctrl_word_in[0] |=> !obj_data_out[0]; endproperty
  a_en1: assert property (p_en1) else $error("ch1 enable");
  property p_en2;
    s_st |=> obj_data_out[8] == $past(ctrl_word_in[8]);
  endproperty
  a_en2: assert property (p_en2) else $error("ch2 enable");
  property p_home; s_st ##0 homing_in |=> !obj_data_out[0]; endproperty
  a_home: assert property (p_home) else $error("homing");
  property p_clr;
    (!ctrl_word_in[8])[*2] ##0 s_st |=> obj_data_out[10:9] == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
endmodule : pcs_props

bind pcs_capture pcs_props u_props (.clk_sys_in, .rstn_in, .ctrl_word_in,
  .homing_in, .obj_rd_in, .obj_index_in, .obj_data_out, .obj_ack_out,
  .obj_err_out);

// File: tb/tb_top.sv
/* Self-checking bench for the capture unit.
   Assumes the master model and checker. */
`timescale 1ns/100ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic homing_in = 1'b0;
  logic enc_zero_in = 1'b0;
  logic [1:0] probe_in = 2'h0;
  pcs_pkg::pcs_word_t ctrl_word_in = 16'h0000;
  pcs_pkg::pcs_pos_t pos_in = 32'h0;
  pcs_pkg::pcs_index_t obj_index_in;
  logic obj_rd_in, obj_ack_out, obj_err_out;
  logic [31:0] obj_data_out;
  logic [32:0] exp_q[$];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] sd = 32'h0001_43C4;
  logic [31:0] p [0:3];
  always #12.5 clk_sys_in = ~clk_sys_in;
  pcs_capture uut (.clk_sys_in, .rstn_in, .ctrl_word_in, .homing_in,
    .probe_in, .enc_zero_in, .pos_in, .obj_rd_in, .obj_index_in,
    .obj_data_out, .obj_ack_out, .obj_err_out);
  pcs_master m (.clk_sys_in, .idx_out(obj_index_in), .rd_out(obj_rd_in));
  task automatic end_of_test;
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value err_data exp %h got %h", e, s);
    end
  endtask : cmp
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction : xorshift
  task automatic rd(input logic [15:0] i, input logic [32:0] e);
    exp_q.push_back(e);
    m.rd(i);
  endtask : rd
  // New random position together with the trigger pins
  task automatic trig(input logic [1:0] pr, input logic ez,
      output logic [31:0] v);
    @(negedge clk_sys_in);
    sd = xorshift(sd);
    v = sd;
    pos_in = v;
    probe_in = pr;
    enc_zero_in = ez;
    repeat (6) @(negedge clk_sys_in);
  endtask : trig
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      end_of_test();
    end
    #1;
    if (obj_ack_out === 1'b1)
      cmp(exp_q.pop_front(), {obj_err_out, obj_data_out});
  end
  initial begin
    repeat (10) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    rd(16'h60B9, 33'h0);
    rd(16'h60BE, 33'h1_0000_0000);
    rd(16'h60B8, 33'h1_0000_0000);
    ctrl_word_in = 16'h0031;
    trig(2'h1, 1'b0, p[0]);
    rd(16'h60B9, 33'h3);
    rd(16'h60BA, {1'b0, p[0]});
    trig(2'h0, 1'b0, p[1]);
    rd(16'h60B9, 33'h7);
    rd(16'h60BB, {1'b0, p[1]});
    trig(2'h1, 1'b0, p[2]);
    rd(16'h60BA, {1'b0, p[0]});
    ctrl_word_in = 16'h3731;
    trig(2'h3, 1'b1, p[2]);
    rd(16'h60B9, 33'h8307);
    rd(16'h60BC, {1'b0, p[2]});
    trig(2'h3, 1'b0, p[3]);
    rd(16'h60B9, 33'h0707);
    rd(16'h60BD, {1'b0, p[3]});
    trig(2'h3, 1'b1, p[2]);
    rd(16'h60BC, {1'b0, p[2]});
    homing_in = 1'b1;
    rd(16'h60B9, 33'h8700);
    homing_in = 1'b0;
    rd(16'h60B9, 33'h8700);
    ctrl_word_in = 16'h3730;
    rd(16'h60B9, 33'h8700);
    ctrl_word_in = 16'h3731;
    rd(16'h60B9, 33'h8701);
    ctrl_word_in = 16'h0031;
    rd(16'h60B9, 33'h8001);
    // Channel 1 continuous on probe, channel 2 single, probe, falling only
    ctrl_word_in = 16'h2133;
    trig(2'h0, 1'h1, p[0]);
    rd(16'h60B9, 33'h8585);
    rd(16'h60BB, {1'h0, p[0]});
    rd(16'h60BD, {1'h0, p[0]});
    trig(2'h3, 1'h1, p[1]);
    rd(16'h60B9, 33'h8507);
    rd(16'h60BC, {1'h0, p[2]});
    ctrl_word_in = 16'h0133;
    rd(16'h60B9, 33'h8507);
    ctrl_word_in = 16'h2133;
    rd(16'h60B9, 33'h8107);
    repeat (3) @(negedge clk_sys_in);
    // A read that was never answered counts as a mismatch
    if (exp_q.size() != 0)
      fails++;
    end_of_test();
  end
endmodule : tb_top
